// ### rtl/fcs_pkg.sv
// Package of constants and types for the flash command host controller
package fcs_pkg;
   localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
   localparam logic [7:0] CMD_IDENT = 8'h90;
   localparam logic [7:0] CMD_READ_STATUS = 8'h70;
   localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
   localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
   localparam logic [7:0] CMD_CONFIRM = 8'hD0;
   localparam logic [7:0] CMD_SUSPEND = 8'hB0;
   localparam logic [7:0] CMD_PROGRAM_SETUP = 8'h40;
   localparam int STAT_READY = 7;
   localparam int STAT_SUSPENDED = 6;
   localparam int STAT_ERASE_ERR = 5;
   localparam int STAT_PROG_ERR = 4;
   localparam int STAT_SUPPLY_LOW = 3;
   localparam logic [7:0] STAT_USED_MASK = 8'hF8;
   localparam logic [16:0] IDENT_MAKER_ADDR = 17'h00000;
   localparam logic [16:0] IDENT_PART_ADDR = 17'h00001;
   // Strobe timing in 5 ns cycles
   localparam int CLK_PERIOD_NS = 5;
   localparam int T_SETUP_NS = 50;
   localparam int T_PULSE_NS = 50;
   localparam int T_HOLD_NS = 30;
   localparam logic [3:0] SETUP_CYC = 4'((T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [3:0] PULSE_CYC = 4'((T_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [3:0] HOLD_CYC = 4'((T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [16:0] ADDR_RESET = 17'h00000;
   localparam logic [7:0] DATA_RESET = 8'h00;

   typedef enum logic [3:0] {
      OP_READ_ARRAY, OP_IDENT, OP_READ_STATUS, OP_CLEAR_STATUS,
      OP_ERASE, OP_PROGRAM, OP_SUSPEND, OP_RESUME, OP_READ
   } fcs_op_t;

   typedef struct packed {
      fcs_op_t op;
      logic [16:0] addr;
      logic [7:0] data;
   } fcs_req_t;

   typedef struct packed {
      logic ce_b;
      logic oe_b;
      logic we_b;
      logic [16:0] addr;
      logic [7:0] dq_out;
      logic dq_oe;
   } fcs_pins_t;
endpackage

// ### rtl/fcs_bus_cycle.sv
// One strobe cycle on the flash byte bus, write or read
`timescale 1ns/1ps
`default_nettype none
module fcs_bus_cycle
   import fcs_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic start,
   input wire logic is_write,
   input wire logic [16:0] addr,
   input wire logic [7:0] data,
   input wire logic [7:0] dq_in_sync,
   output fcs_pins_t pins,
   output logic done,
   output logic [7:0] rdata
);
   typedef enum logic [1:0] {S_IDLE, S_SETUP, S_PULSE, S_HOLD} fcs_cyc_t;
   fcs_cyc_t state, next_state;
   logic [3:0] cnt, next_cnt;
   fcs_pins_t next_pins;
   logic next_done;
   logic [7:0] next_rdata;
   logic wr, next_wr;

   always_comb begin
      next_state = state;
      next_cnt = cnt;
      next_pins = pins;
      next_done = 1'b0;
      next_rdata = rdata;
      next_wr = wr;
      case (state)
         S_IDLE: begin
            if (start) begin
               next_wr = is_write;
               next_pins.addr = addr;
               next_pins.dq_out = data;
               next_pins.dq_oe = is_write;
               next_pins.ce_b = 1'b0;
               next_cnt = SETUP_CYC;
               next_state = S_SETUP;
            end
         end
         S_SETUP: begin
            next_cnt = cnt - 4'h1;
            if (cnt == 4'h1) begin
               if (wr) begin
                  next_pins.we_b = 1'b0;
               end else begin
                  next_pins.oe_b = 1'b0;
               end
               next_cnt = PULSE_CYC;
               next_state = S_PULSE;
            end
         end
         S_PULSE: begin
            next_cnt = cnt - 4'h1;
            if (cnt == 4'h1) begin
               if (!wr) begin
                  next_rdata = dq_in_sync;
               end
               next_pins.we_b = 1'b1;
               next_pins.oe_b = 1'b1;
               next_cnt = HOLD_CYC;
               next_state = S_HOLD;
            end
         end
         default: begin
            next_cnt = cnt - 4'h1;
            if (cnt == 4'h1) begin
               // Select released every cycle so each status read is fresh
               next_pins.ce_b = 1'b1;
               next_pins.dq_oe = 1'b0;
               next_done = 1'b1;
               next_state = S_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         state <= S_IDLE;
         cnt <= 4'h0;
         pins <= '{ce_b: 1'b1, oe_b: 1'b1, we_b: 1'b1, addr: ADDR_RESET, dq_out: DATA_RESET, dq_oe: 1'b0};
         done <= 1'b0;
         rdata <= DATA_RESET;
         wr <= 1'b0;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         pins <= next_pins;
         done <= next_done;
         rdata <= next_rdata;
         wr <= next_wr;
      end
   end
endmodule
`default_nettype wire

// ### rtl/fcs_host.sv
// Host controller issuing flash commands and reads over the byte bus
`timescale 1ns/1ps
`default_nettype none
module fcs_host
   import fcs_pkg::*;
(
   input wire logic CLK,
   input wire logic RST_B,
   input wire logic REQ_VALID,
   input wire fcs_pkg::fcs_req_t REQ,
   output logic REQ_READY,
   output logic RSP_VALID,
   output logic [7:0] RSP_DATA,
   output logic RSP_ERROR,
   output logic ENGINE_READY,
   output logic FLASH_CE_B,
   output logic FLASH_OE_B,
   output logic FLASH_WE_B,
   output logic [16:0] FLASH_ADDR,
   output logic [7:0] FLASH_DQ_OUT,
   output logic FLASH_DQ_OE,
   input wire logic [7:0] FLASH_DQ_IN
);
   typedef enum logic [2:0] {H_IDLE, H_FIRST, H_SECOND, H_DONE} fcs_host_t;
   fcs_host_t state, next_state;
   fcs_req_t cur, next_cur;
   logic [7:0] dq_meta, dq_sync;
   logic start, is_write;
   logic [16:0] cyc_addr;
   logic [7:0] cyc_data;
   fcs_pins_t pins;
   logic cyc_done;
   logic [7:0] cyc_rdata;
   logic next_rsp_valid, next_rsp_error, next_req_ready, next_ready;
   logic [7:0] next_rsp_data;
   logic busy_prog, next_busy_prog;

   // Pin input synchroniser
   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         dq_meta <= DATA_RESET;
         dq_sync <= DATA_RESET;
      end else begin
         dq_meta <= FLASH_DQ_IN;
         dq_sync <= dq_meta;
      end
   end

   fcs_bus_cycle u_cyc (
      .clk(CLK),
      .rst_b(RST_B),
      .start(start),
      .is_write(is_write),
      .addr(cyc_addr),
      .data(cyc_data),
      .dq_in_sync(dq_sync),
      .pins(pins),
      .done(cyc_done),
      .rdata(cyc_rdata)
   );

   // First write of each command, second write for two-cycle ones
   always_comb begin
      start = 1'b0;
      is_write = 1'b1;
      cyc_addr = cur.addr;
      cyc_data = CMD_READ_ARRAY;
      next_state = state;
      next_cur = cur;
      next_rsp_valid = 1'b0;
      next_rsp_data = RSP_DATA;
      next_rsp_error = RSP_ERROR;
      next_req_ready = 1'b0;
      next_ready = ENGINE_READY;
      next_busy_prog = busy_prog;
      case (cur.op)
         OP_READ_ARRAY: cyc_data = CMD_READ_ARRAY;
         OP_IDENT: cyc_data = CMD_IDENT;
         OP_READ_STATUS: cyc_data = CMD_READ_STATUS;
         OP_CLEAR_STATUS: cyc_data = CMD_CLEAR_STATUS;
         OP_ERASE: cyc_data = CMD_ERASE_SETUP;
         OP_PROGRAM: cyc_data = CMD_PROGRAM_SETUP;
         OP_SUSPEND: cyc_data = CMD_SUSPEND;
         OP_RESUME: cyc_data = CMD_CONFIRM;
         default: is_write = 1'b0;
      endcase
      if (state == H_SECOND) begin
         // Same address both writes
         cyc_data = (cur.op == OP_ERASE) ? CMD_CONFIRM : cur.data;
      end
      case (state)
         H_IDLE: begin
            next_req_ready = 1'b1;
            if (REQ_VALID && REQ_READY) begin
               next_req_ready = 1'b0;
               next_cur = REQ;
               next_state = H_FIRST;
            end
         end
         H_FIRST: begin
            // Only status reads and reads while programming runs
            if (busy_prog && cur.op != OP_READ_STATUS && cur.op != OP_READ) begin
               next_rsp_error = 1'b1;
               next_state = H_DONE;
            end else begin
               start = 1'b1;
               next_state = H_SECOND;
               if (cur.op != OP_ERASE && cur.op != OP_PROGRAM) begin
                  next_state = H_DONE;
               end
               next_rsp_error = 1'b0;
            end
         end
         H_SECOND: begin
            if (cyc_done) begin
               start = 1'b1;
               next_busy_prog = (cur.op == OP_PROGRAM);
               next_ready = 1'b0;
               next_state = H_DONE;
            end
         end
         default: begin
            if (cyc_done || next_rsp_error && !start) begin
               if (cur.op == OP_READ) begin
                  // Only the ready bit is interpreted, reserved bits ignored
                  next_rsp_data = cyc_rdata;
                  next_ready = cyc_rdata[STAT_READY];
                  if (cyc_rdata[STAT_READY]) begin
                     next_busy_prog = 1'b0;
                  end
               end
               next_rsp_valid = 1'b1;
               next_req_ready = 1'b1;
               next_state = H_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         state <= H_IDLE;
         cur <= '{op: OP_READ, addr: ADDR_RESET, data: DATA_RESET};
         REQ_READY <= 1'b0;
         RSP_VALID <= 1'b0;
         RSP_DATA <= DATA_RESET;
         RSP_ERROR <= 1'b0;
         ENGINE_READY <= 1'b1;
         busy_prog <= 1'b0;
      end else begin
         state <= next_state;
         cur <= next_cur;
         REQ_READY <= next_req_ready;
         RSP_VALID <= next_rsp_valid;
         RSP_DATA <= next_rsp_data;
         RSP_ERROR <= next_rsp_error;
         ENGINE_READY <= next_ready;
         busy_prog <= next_busy_prog;
      end
   end

   // Pins straight from the cycle engine flops
   assign FLASH_CE_B = pins.ce_b;
   assign FLASH_OE_B = pins.oe_b;
   assign FLASH_WE_B = pins.we_b;
   assign FLASH_ADDR = pins.addr;
   assign FLASH_DQ_OUT = pins.dq_out;
   assign FLASH_DQ_OE = pins.dq_oe;
endmodule
`default_nettype wire

// ### verification/fcs_host_asserts.sv
// Port assertions for the flash host controller
`timescale 1ns/1ps
`default_nettype none
module fcs_host_asserts
   import fcs_pkg::*;
(
   input wire logic CLK,
   input wire logic RST_B,
   input wire logic REQ_VALID,
   input wire logic REQ_READY,
   input wire logic RSP_VALID,
   input wire logic RSP_ERROR,
   input wire logic FLASH_CE_B,
   input wire logic FLASH_OE_B,
   input wire logic FLASH_WE_B,
   input wire logic [16:0] FLASH_ADDR,
   input wire logic [7:0] FLASH_DQ_OUT,
   input wire logic FLASH_DQ_OE
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_B);
   sequence s_we_low;
      !FLASH_WE_B [*8];
   endsequence
   sequence s_we_end;
      ##[0:3] FLASH_WE_B ##[1:8] FLASH_CE_B;
   endsequence
   a_we_select: assert property (!FLASH_WE_B |-> !FLASH_CE_B && FLASH_OE_B)
      else $error("write strobe outside select");
   a_we_drive: assert property (!FLASH_WE_B |-> FLASH_DQ_OE)
      else $error("data not driven in write");
   a_read_float: assert property (!FLASH_OE_B |-> !FLASH_DQ_OE && !FLASH_CE_B)
      else $error("bad read strobes");
   a_we_pulse: assert property ($fell(FLASH_WE_B) |-> s_we_low ##1 s_we_end)
      else $error("write pulse shape");
   a_latch_stable: assert property (!FLASH_WE_B && $past(!FLASH_WE_B) |-> $stable(FLASH_ADDR) && $stable(FLASH_DQ_OUT))
      else $error("address or data moved in write");
   a_strobe_up: assert property ($rose(FLASH_OE_B) |-> ##[1:8] FLASH_CE_B)
      else $error("select not raised after read");
   a_take_drop: assert property (REQ_VALID && REQ_READY |=> !REQ_READY)
      else $error("ready held after take");
   a_rsp_pulse: assert property (RSP_VALID |=> !RSP_VALID)
      else $error("response longer than a cycle");
   a_refuse_quiet: assert property (RSP_VALID && RSP_ERROR |-> FLASH_CE_B && $past(FLASH_CE_B, 2))
      else $error("bus cycle on refused request");
endmodule
bind fcs_host fcs_host_asserts i_fcs_host_asserts (.CLK, .RST_B, .REQ_VALID, .REQ_READY, .RSP_VALID,
   .RSP_ERROR, .FLASH_CE_B, .FLASH_OE_B, .FLASH_WE_B, .FLASH_ADDR, .FLASH_DQ_OUT, .FLASH_DQ_OE);
`default_nettype wire

// ### verification/fcs_flash_model.sv
// Behavioural flash device seen by the host controller
`timescale 1ns/1ps
`default_nettype none
module fcs_flash_model
   import fcs_pkg::*;
#(
   parameter logic [7:0] MAKER_ID = 8'h5A, // Arbitrary value
   parameter logic [7:0] PART_ID = 8'hA6, // Arbitrary value
   parameter int BUSY_NS = 1000
)
(
   input wire logic ce_b,
   input wire logic oe_b,
   input wire logic we_b,
   input wire logic [16:0] addr,
   input wire logic [7:0] din,
   input wire logic vpp_high,
   input wire logic fail,
   output logic [7:0] dout
);
   logic [7:0] sr = 8'h80;
   logic [7:0] snap = 8'h00;
   logic [7:0] held = 8'h00;
   logic [7:0] rd;
   logic [1:0] mode = 2'd0;
   logic [16:0] sa = '0;
   logic es = 0, ps = 0, busy = 0, bad = 0, susp = 0;
   int eb = 4;
   task automatic start(input int b);
      if (!vpp_high) sr[3] = 1'b1;
      else begin
         busy = 1'b1;
         sr[7] = 1'b0;
         eb = b;
      end
   endtask
   always @(posedge we_b) if (!ce_b) begin
      if ((es || ps) && addr != sa) bad = 1'b1;
      mode = (es || ps || din == CMD_READ_STATUS) ? 2'd2 : mode;
      if (ps) start(STAT_PROG_ERR);
      else if (es && din == CMD_CONFIRM) start(STAT_ERASE_ERR);
      else if (es) sr[5:4] = 2'b11;
      else if (busy && !susp && eb == STAT_ERASE_ERR && din == CMD_SUSPEND) begin
         susp = 1'b1;
         sr[7:6] = 2'b11;
      end else if (susp && din == CMD_CONFIRM) begin
         susp = 1'b0;
         sr[7:6] = 2'b00;
      end
      else if (!busy) case (din)
         CMD_READ_ARRAY: mode = 2'd0;
         CMD_IDENT: mode = 2'd1;
         CMD_CLEAR_STATUS: sr[5:3] = 3'b000;
         default: ;
      endcase
      es = !busy && !es && !ps && din == CMD_ERASE_SETUP;
      ps = !busy && !es && !ps && din == CMD_PROGRAM_SETUP;
      sa = addr;
   end
   always @(posedge busy) begin
      #BUSY_NS;
      wait (!susp);
      sr[eb] = sr[eb] | fail;
      sr[7] = 1'b1;
      busy = 1'b0;
   end
   always @(negedge oe_b or negedge ce_b) if (!oe_b && !ce_b) snap = sr;
   always_comb rd = mode == 2'd2 ? snap : mode == 2'd1 ? (addr[0] ? PART_ID : MAKER_ID) : addr[7:0] ^ 8'h3C;
   always @(posedge oe_b) held = ~rd;
   assign dout = (!oe_b && !ce_b) ? rd : held;
endmodule
`default_nettype wire

// ### verification/tb_top.sv
// Self-checking bench for the flash host controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import fcs_pkg::*;
   logic CLK = 0, RST_B = 0, REQ_VALID = 0, vpp = 1, fail = 0;
   fcs_req_t REQ = '0;
   logic REQ_READY, RSP_VALID, RSP_ERROR, ENGINE_READY, CE_B, OE_B, WE_B, DQ_OE;
   logic [16:0] ADDR;
   logic [7:0] RSP_DATA, DQ_OUT, DQ_IN;
   int errors = 0, n_tests = 0;
   initial forever #2.5 CLK = ~CLK;
   fcs_host i_fcs_host (.CLK, .RST_B, .REQ_VALID, .REQ, .REQ_READY, .RSP_VALID, .RSP_DATA, .RSP_ERROR,
      .ENGINE_READY, .FLASH_CE_B(CE_B), .FLASH_OE_B(OE_B), .FLASH_WE_B(WE_B), .FLASH_ADDR(ADDR),
      .FLASH_DQ_OUT(DQ_OUT), .FLASH_DQ_OE(DQ_OE), .FLASH_DQ_IN(DQ_IN));
   fcs_flash_model i_fcs_flash_model (.ce_b(CE_B), .oe_b(OE_B), .we_b(WE_B), .addr(ADDR), .din(DQ_OUT),
      .vpp_high(vpp), .fail(fail), .dout(DQ_IN));
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic complete_run;
      $display("errors=%0d n_tests=%0d", errors, n_tests);
      if (errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic req(input fcs_op_t op, input logic [16:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(negedge CLK);
      REQ = '{op, a, d};
      REQ_VALID = 1;
      while (REQ_READY !== 1'b1 && n < 99) begin @(negedge CLK); n++; end
      if (REQ_READY !== 1'b1) begin
         errors++;
         $display("ERROR %0t: request not taken", $time);
         complete_run;
      end
      @(negedge CLK);
      REQ_VALID = 0;
      while (RSP_VALID !== 1'b1 && n < 499) begin @(negedge CLK); n++; end
      if (n >= 499) begin
         errors++;
         $display("ERROR %0t: no response", $time);
         complete_run;
      end
   endtask
   task automatic poll(input logic [7:0] exp);
      int n;
      n = 0;
      do begin req(OP_READ, 17'h0, 8'h00); n++; end while (RSP_DATA[7] !== 1'b1 && n < 60);
      if (RSP_DATA[7] !== 1'b1) begin
         errors++;
         $display("ERROR %0t: ready timeout", $time);
         complete_run;
      end
      check(RSP_DATA & STAT_USED_MASK, exp);
      check({7'h0, ENGINE_READY}, 8'h01);
   endtask
   task automatic t_ident;
      req(OP_IDENT, 17'h0, 8'h00);
      req(OP_READ, IDENT_MAKER_ADDR, 8'h00);
      check(RSP_DATA, 8'h5A);
      req(OP_READ, IDENT_PART_ADDR, 8'h00);
      check(RSP_DATA, 8'hA6);
      req(OP_READ, IDENT_MAKER_ADDR, 8'h00);
      check(RSP_DATA, 8'h5A);
   endtask
   task automatic t_array;
      req(OP_READ_ARRAY, 17'h0, 8'h00);
      req(OP_READ, 17'h1F0C1, 8'h00);
      check(RSP_DATA, 8'hFD);
   endtask
   task automatic t_program;
      req(OP_PROGRAM, 17'h00123, 8'hA5);
      check({7'h0, ENGINE_READY}, 8'h00);
      req(OP_READ_ARRAY, 17'h0, 8'h00);
      check({7'h0, RSP_ERROR}, 8'h01);
      poll(8'h80);
      check({7'h0, i_fcs_flash_model.bad}, 8'h00);
   endtask
   task automatic t_erase;
      req(OP_ERASE, 17'h04000, 8'h00);
      req(OP_READ_ARRAY, 17'h0, 8'h00);
      req(OP_READ, 17'h04000, 8'h00);
      check({7'h0, RSP_DATA[7]}, 8'h00);
      req(OP_SUSPEND, 17'h0, 8'h00);
      poll(8'hC0);
      req(OP_RESUME, 17'h0, 8'h00);
      poll(8'h80);
   endtask
   task automatic t_errors;
      fail = 1;
      req(OP_PROGRAM, 17'h00200, 8'h3C);
      poll(8'h90);
      req(OP_ERASE, 17'h08000, 8'h00);
      poll(8'hB0);
      fail = 0;
      req(OP_CLEAR_STATUS, 17'h0, 8'h00);
      req(OP_READ_STATUS, 17'h0, 8'h00);
      poll(8'h80);
      vpp = 0;
      req(OP_PROGRAM, 17'h00300, 8'h11);
      poll(8'h88);
      req(OP_IDENT, 17'h0, 8'h00);
      req(OP_READ, IDENT_PART_ADDR, 8'h00);
      check(RSP_DATA, 8'hA6);
      req(OP_CLEAR_STATUS, 17'h0, 8'h00);
      req(OP_READ_STATUS, 17'h0, 8'h00);
      poll(8'h80);
      vpp = 1;
   endtask
   initial begin
      repeat (3) @(negedge CLK);
      RST_B = 1;
      repeat (2) @(negedge CLK);
      t_ident;
      t_array;
      t_program;
      t_erase;
      t_errors;
      complete_run;
   end
endmodule
`default_nettype wire
